// ==== rtl/fscs_cfg.svh ====
// Register map, field positions, reset values and sizes of the configuration shadow block
`ifndef FSCS_CFG_SVH
`define FSCS_CFG_SVH

`define FSCS_AW              9
`define FSCS_DW              16

`define FSCS_ADDR_TARGET     9'h080
`define FSCS_ADDR_MODE       9'h0C0
`define FSCS_ADDR_WIN_EN_LO  9'h0C3
`define FSCS_ADDR_WIN_EN_HI  9'h0C4
`define FSCS_ADDR_BLACK      9'h0C5
`define FSCS_ADDR_MULT       9'h0C7
`define FSCS_ADDR_FRLEN      9'h0C8
`define FSCS_ADDR_EXPO       9'h0C9
`define FSCS_ADDR_GAIN       9'h0CC
`define FSCS_ADDR_SYNC       9'h0CE
`define FSCS_ADDR_WIN_BASE   9'h100
`define FSCS_ADDR_WIN_LAST   9'h15F

`define FSCS_BIT_SUBS        7
`define FSCS_BIT_BIN         8
`define FSCS_SYNC_BL         0
`define FSCS_SYNC_EXP        1
`define FSCS_SYNC_GAIN       2
`define FSCS_SYNC_ROI        3
`define FSCS_SYNC_W          4

`define FSCS_COLGAIN_MSB     4
`define FSCS_COLGAIN_LSB     0
`define FSCS_AFEGAIN_MSB     7
`define FSCS_AFEGAIN_LSB     5
`define FSCS_BL_MSB          7
`define FSCS_BL_LSB          0
`define FSCS_TGT_MSB         9
`define FSCS_TGT_LSB         0

`define FSCS_SYNC_RST        4'hF
`define FSCS_WIN_EN_LO_RST   16'h0001
`define FSCS_BLACK_RST       16'h0001
`define FSCS_WORD_RST        16'h0000

`define FSCS_WIN_WORDS       96
`define FSCS_WIN_IW          7
`define FSCS_KERNEL_COLS     64
`define FSCS_COL_W           6
`define FSCS_PIX_W           10
`define FSCS_PIX_MAX         10'h3FF

`endif

// ==== rtl/fscs_pkg.sv ====
// Types shared by the configuration shadow block
package fscs_pkg;
  typedef logic [8:0]  fscs_addr_type;
  typedef logic [15:0] fscs_word_type;
  typedef enum logic [1:0] {
    FSCS_IDLE  = 2'b00,
    FSCS_DARK  = 2'b01,
    FSCS_IMAGE = 2'b11
  } fscs_dark_state_type;
endpackage

// ==== rtl/fscs_mem.sv ====
// Small two-read-port memory with registered read data
`timescale 1ns/1ns
module fscs_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 96,
  parameter int AW    = 7
) (
  // Clock
  input  wire logic             i_clk,
  // Write port
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_waddr,
  input  wire logic [WIDTH-1:0] i_wdata,
  // Read ports
  input  wire logic [AW-1:0]    i_raddr_a,
  output logic      [WIDTH-1:0] o_rdata_a,
  input  wire logic [AW-1:0]    i_raddr_b,
  output logic      [WIDTH-1:0] o_rdata_b
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    o_rdata_a <= mem_r[i_raddr_a];
    o_rdata_b <= mem_r[i_raddr_b];
  end
endmodule

// ==== rtl/fscs_top.sv ====
// Frame-synchronised configuration shadow, window enables and black-level offsets
// Notes on behaviour
// - With a group's gate at 1, new values go active only at frame start.
// - With a group's gate at 0, writes are stored but active values stay.
// - Setting a gate back to 1 loads pending values at next frame start.
// - Group gate bits live in one register at address 206.
// - Dark-row gate controls transfer of the dark-row count.
// - Integration gate jointly controls tick multiplier, frame length, integration time.
// - Amplification gate jointly controls column and front-end gain.
// - Window gate jointly controls both enable words, subsampling and binning.
// - Window geometry words are never frozen by the window gate.
// - Thirty-two windows defined by registers 256 to 351.
// - Each window has its own enable bit in registers 195 and 196.
// - Geometry of disabled windows may be rewritten during acquisition.
// - Each frame begins with a programmable number of dark rows, 1 to 255; a count of 0 gives one.
// - Black level is driven to a programmable target, clipped at zero.
// - One offset per kernel column, 64 in all, applied to its column.
`timescale 1ns/1ns
`include "fscs_cfg.svh"
module fscs_top (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_b,
  // Register port from the serial decoder
  input  wire fscs_pkg::fscs_addr_type i_reg_addr,
  input  wire fscs_pkg::fscs_word_type i_reg_wdata,
  input  wire logic                    i_reg_wr,
  input  wire logic                    i_reg_rd,
  output fscs_pkg::fscs_word_type      o_reg_rdata,
  output logic                         o_reg_rvalid,
  // Sequencer timing
  input  wire logic                    i_frame_start,
  input  wire logic                    i_row_end,
  // Active configuration
  output logic [7:0]                   o_act_black_lines,
  output logic [15:0]                  o_act_mult_timer,
  output logic [15:0]                  o_act_frame_period_length,
  output logic [15:0]                  o_act_exposure,
  output logic [4:0]                   o_act_col_gain,
  output logic [2:0]                   o_act_afe_gain,
  output logic [31:0]                  o_act_win_en,
  output logic                         o_act_subsample,
  output logic                         o_act_binning,
  // Window geometry lookup
  input  wire logic [6:0]              i_geom_addr,
  output logic [15:0]                  o_geom_data,
  // Pixel path
  output logic                         o_dark_row,
  input  wire logic                    i_pix_valid,
  input  wire logic [5:0]              i_pix_col,
  input  wire logic [9:0]              i_pix_data,
  output logic                         o_pix_valid,
  output logic [9:0]                   o_pix_data
);
  import fscs_pkg::*;

  function automatic logic is_win(input fscs_addr_type a);
    is_win = (a >= `FSCS_ADDR_WIN_BASE) && (a <= `FSCS_ADDR_WIN_LAST);
  endfunction

  // Pending (written) copies
  fscs_word_type pend_mode_r;
  fscs_word_type pend_win_lo_r;
  fscs_word_type pend_win_hi_r;
  fscs_word_type pend_black_r;
  fscs_word_type pend_mult_r;
  fscs_word_type pend_frlen_r;
  fscs_word_type pend_expo_r;
  fscs_word_type pend_gain_r;
  fscs_word_type target_r;
  logic [`FSCS_SYNC_W-1:0] sync_r;

  fscs_dark_state_type dark_state_r;
  logic [7:0]          row_cnt_r;
  logic [8:0]          row_cnt_nxt;

  fscs_word_type rd_mux;
  fscs_word_type rd_data_r;
  logic          rd_win_r;
  logic          rd_v1_r;
  fscs_word_type win_q;
  logic [8:0]    win_off;
  logic          win_we;

  logic [10:0]   off_q;
  logic [10:0]   off_wdata;
  logic          off_we;
  logic          p1_valid_r;
  logic          p1_dark_r;
  logic [9:0]    p1_data_r;
  logic [11:0]   p1_sum;

  // Pending register writes; geometry goes to memory ungated
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pend_mode_r   <= `FSCS_WORD_RST;
      pend_win_lo_r <= `FSCS_WIN_EN_LO_RST;
      pend_win_hi_r <= `FSCS_WORD_RST;
      pend_black_r  <= `FSCS_BLACK_RST;
      pend_mult_r   <= `FSCS_WORD_RST;
      pend_frlen_r  <= `FSCS_WORD_RST;
      pend_expo_r   <= `FSCS_WORD_RST;
      pend_gain_r   <= `FSCS_WORD_RST;
      target_r      <= `FSCS_WORD_RST;
      sync_r        <= `FSCS_SYNC_RST;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `FSCS_ADDR_MODE:      pend_mode_r   <= i_reg_wdata;
        `FSCS_ADDR_WIN_EN_LO: pend_win_lo_r <= i_reg_wdata;
        `FSCS_ADDR_WIN_EN_HI: pend_win_hi_r <= i_reg_wdata;
        `FSCS_ADDR_BLACK:     pend_black_r  <= i_reg_wdata;
        `FSCS_ADDR_MULT:      pend_mult_r   <= i_reg_wdata;
        `FSCS_ADDR_FRLEN:     pend_frlen_r  <= i_reg_wdata;
        `FSCS_ADDR_EXPO:      pend_expo_r   <= i_reg_wdata;
        `FSCS_ADDR_GAIN:      pend_gain_r   <= i_reg_wdata;
        `FSCS_ADDR_TARGET:    target_r      <= i_reg_wdata;
        `FSCS_ADDR_SYNC:      sync_r        <= i_reg_wdata[`FSCS_SYNC_W-1:0];
        default: ;
      endcase
    end
  end

  // Window geometry: 96 words, writable at any time
  assign win_off = i_reg_addr - `FSCS_ADDR_WIN_BASE;
  assign win_we  = i_reg_wr && is_win(i_reg_addr);

  fscs_mem #(
    .WIDTH (16),
    .DEPTH (`FSCS_WIN_WORDS),
    .AW    (`FSCS_WIN_IW)
  ) u_win_mem (
    .i_clk     (i_clk),
    .i_we      (win_we),
    .i_waddr   (win_off[6:0]),
    .i_wdata   (i_reg_wdata),
    .i_raddr_a (win_off[6:0]),
    .o_rdata_a (win_q),
    .i_raddr_b (i_geom_addr),
    .o_rdata_b (o_geom_data)
  );

  // Dark-row group
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_act_black_lines <= 8'(`FSCS_BLACK_RST);
    end else if (i_frame_start && sync_r[`FSCS_SYNC_BL]) begin
      o_act_black_lines <= pend_black_r[`FSCS_BL_MSB:`FSCS_BL_LSB];
    end
  end

  // Integration group
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_act_mult_timer          <= `FSCS_WORD_RST;
      o_act_frame_period_length <= `FSCS_WORD_RST;
      o_act_exposure            <= `FSCS_WORD_RST;
    end else if (i_frame_start && sync_r[`FSCS_SYNC_EXP]) begin
      o_act_mult_timer          <= pend_mult_r;
      o_act_frame_period_length <= pend_frlen_r;
      o_act_exposure            <= pend_expo_r;
    end
  end

  // Amplification group
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_act_col_gain <= 5'h00;
      o_act_afe_gain <= 3'h0;
    end else if (i_frame_start && sync_r[`FSCS_SYNC_GAIN]) begin
      o_act_col_gain <= pend_gain_r[`FSCS_COLGAIN_MSB:`FSCS_COLGAIN_LSB];
      o_act_afe_gain <= pend_gain_r[`FSCS_AFEGAIN_MSB:`FSCS_AFEGAIN_LSB];
    end
  end

  // Window-selection group
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_act_win_en    <= {`FSCS_WORD_RST, `FSCS_WIN_EN_LO_RST};
      o_act_subsample <= 1'b0;
      o_act_binning   <= 1'b0;
    end else if (i_frame_start && sync_r[`FSCS_SYNC_ROI]) begin
      o_act_win_en    <= {pend_win_hi_r, pend_win_lo_r};
      o_act_subsample <= pend_mode_r[`FSCS_BIT_SUBS];
      o_act_binning   <= pend_mode_r[`FSCS_BIT_BIN];
    end
  end

  // Read-back mux; unmapped addresses read zero
  always_comb begin
    rd_mux = `FSCS_WORD_RST;
    case (i_reg_addr)
      `FSCS_ADDR_MODE:      rd_mux = pend_mode_r;
      `FSCS_ADDR_WIN_EN_LO: rd_mux = pend_win_lo_r;
      `FSCS_ADDR_WIN_EN_HI: rd_mux = pend_win_hi_r;
      `FSCS_ADDR_BLACK:     rd_mux = pend_black_r;
      `FSCS_ADDR_MULT:      rd_mux = pend_mult_r;
      `FSCS_ADDR_FRLEN:     rd_mux = pend_frlen_r;
      `FSCS_ADDR_EXPO:      rd_mux = pend_expo_r;
      `FSCS_ADDR_GAIN:      rd_mux = pend_gain_r;
      `FSCS_ADDR_TARGET:    rd_mux = target_r;
      `FSCS_ADDR_SYNC:      rd_mux = {12'h000, sync_r};
      default:              rd_mux = `FSCS_WORD_RST;
    endcase
  end

  // Two-cycle read pipeline so memory words come out of a register too
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rd_v1_r      <= 1'b0;
      rd_win_r     <= 1'b0;
      rd_data_r    <= `FSCS_WORD_RST;
      o_reg_rvalid <= 1'b0;
      o_reg_rdata  <= `FSCS_WORD_RST;
    end else begin
      rd_v1_r      <= i_reg_rd;
      rd_win_r     <= is_win(i_reg_addr);
      rd_data_r    <= rd_mux;
      o_reg_rvalid <= rd_v1_r;
      if (rd_v1_r) begin
        o_reg_rdata <= rd_win_r ? win_q : rd_data_r;
      end
    end
  end

  // Dark-row sequencing at the head of each frame
  assign row_cnt_nxt = {1'b0, row_cnt_r} + 9'h001;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      dark_state_r <= FSCS_IDLE;
      row_cnt_r    <= 8'h00;
      o_dark_row   <= 1'b0;
    end else if (i_frame_start) begin
      dark_state_r <= FSCS_DARK;
      row_cnt_r    <= 8'h00;
      o_dark_row   <= 1'b1;
    end else begin
      case (dark_state_r)
        FSCS_DARK: begin
          if (i_row_end) begin
            row_cnt_r <= row_cnt_nxt[7:0];
            if (row_cnt_nxt >= {1'b0, o_act_black_lines}) begin
              dark_state_r <= FSCS_IMAGE;
              o_dark_row   <= 1'b0;
            end
          end
        end
        FSCS_IMAGE: dark_state_r <= FSCS_IMAGE;
        FSCS_IDLE:  dark_state_r <= FSCS_IDLE;
        default: begin
          dark_state_r <= FSCS_IDLE;
          o_dark_row   <= 1'b0;
        end
      endcase
    end
  end

  // Per-column offsets learnt from dark samples: target minus sample
  assign off_we    = i_pix_valid && (dark_state_r == FSCS_DARK);
  assign off_wdata = {1'b0, target_r[`FSCS_TGT_MSB:`FSCS_TGT_LSB]} - {1'b0, i_pix_data};

  fscs_mem #(
    .WIDTH (11),
    .DEPTH (`FSCS_KERNEL_COLS),
    .AW    (`FSCS_COL_W)
  ) u_off_mem (
    .i_clk     (i_clk),
    .i_we      (off_we),
    .i_waddr   (i_pix_col),
    .i_wdata   (off_wdata),
    .i_raddr_a (i_pix_col),
    .o_rdata_a (off_q),
    .i_raddr_b (i_pix_col),
    .o_rdata_b ()
  );

  // Pixel stage 1 waits for the offset read
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      p1_valid_r <= 1'b0;
      p1_dark_r  <= 1'b0;
      p1_data_r  <= 10'h000;
    end else begin
      p1_valid_r <= i_pix_valid;
      p1_dark_r  <= (dark_state_r == FSCS_DARK);
      p1_data_r  <= i_pix_data;
    end
  end

  assign p1_sum = {2'b00, p1_data_r} + {off_q[10], off_q};

  // Dark samples pass raw; image pixels are offset and clipped to 0..max
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_pix_valid <= 1'b0;
      o_pix_data  <= 10'h000;
    end else begin
      o_pix_valid <= p1_valid_r;
      if (p1_dark_r) begin
        o_pix_data <= p1_data_r;
      end else if (p1_sum[11]) begin
        o_pix_data <= 10'h000;
      end else if (p1_sum[10]) begin
        o_pix_data <= `FSCS_PIX_MAX;
      end else begin
        o_pix_data <= p1_sum[9:0];
      end
    end
  end

  // Checks
  a_mid_frame_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_frame_start |=> $stable(o_act_frame_period_length) && $stable(o_act_win_en))
    else $error("Active configuration changed inside a frame");

  a_frozen_exp_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_frame_start && !sync_r[`FSCS_SYNC_EXP]) |=> $stable(o_act_exposure))
    else $error("Integration group moved while gated off");

  a_exp_group_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_frame_start && sync_r[`FSCS_SYNC_EXP]) |=>
      (o_act_exposure == $past(pend_expo_r)) && (o_act_mult_timer == $past(pend_mult_r)))
    else $error("Integration group not loaded at frame start");

  a_bl_group_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_frame_start && sync_r[`FSCS_SYNC_BL]) |=> o_act_black_lines == $past(pend_black_r[7:0]))
    else $error("Dark-row count not loaded at frame start");

  a_gain_group_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_frame_start && sync_r[`FSCS_SYNC_GAIN]) |=> o_act_afe_gain == $past(pend_gain_r[7:5]))
    else $error("Gain group not loaded at frame start");

  a_roi_group_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_frame_start && sync_r[`FSCS_SYNC_ROI]) |=>
      o_act_win_en == {$past(pend_win_hi_r), $past(pend_win_lo_r)})
    else $error("Window enables not loaded at frame start");

  a_gate_reset: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !$past(i_rst_b) |-> sync_r == `FSCS_SYNC_RST)
    else $error("Gate bits not all set after reset");

  a_dark_start: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_frame_start |=> o_dark_row && (row_cnt_r == 8'h00))
    else $error("Frame did not open with dark rows");

  a_dark_raw: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_pix_valid && dark_state_r == FSCS_DARK && !i_frame_start) ##1 1'b1
      |=> o_pix_valid && (o_pix_data == $past(i_pix_data, 2)))
    else $error("Dark sample was altered");

  c_roi_frozen: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    i_frame_start && !sync_r[`FSCS_SYNC_ROI]);
  c_dark_done: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(o_dark_row));
  c_pix_clip: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    p1_valid_r && !p1_dark_r && p1_sum[11]);
endmodule

// ==== testbench/fscs_host.sv ====
// Register-port host model that configures the shadow block
`timescale 1ns/1ns
`include "fscs_cfg.svh"
module fscs_host (
  // Clock
  input  wire logic                    i_clk,
  // Read answer
  input  wire fscs_pkg::fscs_word_type i_rdata,
  input  wire logic                    i_rvalid,
  // Requests
  output fscs_pkg::fscs_addr_type      o_addr,
  output fscs_pkg::fscs_word_type      o_wdata,
  output logic                         o_wr,
  output logic                         o_rd
);
  import fscs_pkg::*;

  initial begin
    o_addr  = 9'h1AA;
    o_wdata = 16'h5A5A;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // Released lines show the inverse so stale values cannot pass for fresh ones
  task automatic wr(input fscs_addr_type a, input fscs_word_type d);
    @(negedge i_clk);
    o_addr  = a;
    o_wdata = d;
    o_wr    = 1'b1;
    @(negedge i_clk);
    o_wr    = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask

  task automatic rd(input fscs_addr_type a, output fscs_word_type d, output logic ok);
    int n;
    ok = 1'b0;
    d  = 16'h0000;
    @(negedge i_clk);
    o_addr = a;
    o_rd   = 1'b1;
    @(negedge i_clk);
    o_rd   = 1'b0;
    o_addr = ~a;
    for (n = 0; n < 4 && !ok; n++) begin
      @(negedge i_clk);
      if (i_rvalid === 1'b1) begin
        ok = 1'b1;
        d  = i_rdata;
      end
    end
  endtask

  // Only the low enable word is sent when no window above 15 is defined
  task automatic set_windows(input logic [31:0] en, input int count);
    wr(`FSCS_ADDR_WIN_EN_LO, en[15:0]);
    if (count > 16) begin
      wr(`FSCS_ADDR_WIN_EN_HI, en[31:16]);
    end
  endtask
endmodule

// ==== testbench/test_fscs_top.sv ====
// Self-checking bench for the configuration shadow block
`timescale 1ns/1ns
`include "fscs_cfg.svh"
`define FSCS_CHK(act, exp) \
  begin \
    num_checks++; \
    if ((act) !== (exp)) begin \
      $display("BAD t=%0t got=%h exp=%h", $time, (act), (exp)); \
      num_errors++; \
    end \
  end
module test_fscs_top;
  import fscs_pkg::*;
  logic          i_clk = 1'b0;
  logic          rst_b = 1'b0;
  fscs_addr_type reg_addr;
  fscs_word_type reg_wdata;
  fscs_word_type reg_rdata;
  logic          reg_wr;
  logic          reg_rd;
  logic          reg_rvalid;
  logic          frame_start = 1'b0;
  logic          row_end = 1'b0;
  logic [7:0]    bl;
  logic [15:0]   mult;
  logic [15:0]   frlen;
  logic [15:0]   expo;
  logic [4:0]    colg;
  logic [2:0]    afeg;
  logic [31:0]   win;
  logic          subs;
  logic          binn;
  logic [6:0]    geom_addr = 7'h00;
  logic [15:0]   geom_data;
  logic          dark_row;
  logic          pix_valid = 1'b0;
  logic [5:0]    pix_col = 6'h00;
  logic [9:0]    pix_data = 10'h000;
  logic          opix_valid;
  logic [9:0]    opix_data;
  logic [97:0]   act;
  logic [97:0]   exp_act;
  int            num_errors = 0;
  int            num_checks = 0;
  int            g;
  int            r;
  fscs_addr_type ra [4] = '{`FSCS_ADDR_BLACK, `FSCS_ADDR_EXPO, `FSCS_ADDR_GAIN, `FSCS_ADDR_MODE};
  fscs_word_type rv [4] = '{16'h0003, 16'h3333, 16'h00B5, 16'h0180};
  logic [97:0]   msk [4] = '{{8'hFF, 90'h0}, {8'h00, 48'hFFFF_FFFF_FFFF, 42'h0},
                             {56'h0, 8'hFF, 34'h0}, {64'h0, 34'h3_FFFF_FFFF}};
  logic [97:0]   nv = {8'h03, 16'h1111, 16'h2222, 16'h3333, 5'h15, 3'h5,
                       32'h5A5A_A5A5, 1'b1, 1'b1};

  assign act = {bl, mult, frlen, expo, colg, afeg, win, subs, binn};

  always #20 i_clk = ~i_clk;

  fscs_host i_fscs_host (
    .i_clk    (i_clk),
    .i_rdata  (reg_rdata),
    .i_rvalid (reg_rvalid),
    .o_addr   (reg_addr),
    .o_wdata  (reg_wdata),
    .o_wr     (reg_wr),
    .o_rd     (reg_rd)
  );

  fscs_top i_fscs_top (
    .i_clk                     (i_clk),
    .i_rst_b                   (rst_b),
    .i_reg_addr                (reg_addr),
    .i_reg_wdata               (reg_wdata),
    .i_reg_wr                  (reg_wr),
    .i_reg_rd                  (reg_rd),
    .o_reg_rdata               (reg_rdata),
    .o_reg_rvalid              (reg_rvalid),
    .i_frame_start             (frame_start),
    .i_row_end                 (row_end),
    .o_act_black_lines         (bl),
    .o_act_mult_timer          (mult),
    .o_act_frame_period_length (frlen),
    .o_act_exposure            (expo),
    .o_act_col_gain            (colg),
    .o_act_afe_gain            (afeg),
    .o_act_win_en              (win),
    .o_act_subsample           (subs),
    .o_act_binning             (binn),
    .i_geom_addr               (geom_addr),
    .o_geom_data               (geom_data),
    .o_dark_row                (dark_row),
    .i_pix_valid               (pix_valid),
    .i_pix_col                 (pix_col),
    .i_pix_data                (pix_data),
    .o_pix_valid               (opix_valid),
    .o_pix_data                (opix_data)
  );

  task automatic stop_test();
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input fscs_addr_type a, input fscs_word_type e);
    fscs_word_type d;
    logic          ok;
    i_fscs_host.rd(a, d, ok);
    if (!ok) begin
      num_errors++;
      stop_test();
    end else begin
      `FSCS_CHK(d, e)
    end
  endtask

  // One-cycle pulse, then one more cycle for the active set to settle
  task automatic pulse(input int which);
    @(negedge i_clk);
    if (which == 0) frame_start = 1'b1;
    else row_end = 1'b1;
    @(negedge i_clk);
    frame_start = 1'b0;
    row_end     = 1'b0;
    @(negedge i_clk);
  endtask

  task automatic pix(input logic [5:0] c, input logic [9:0] d, input logic [9:0] e);
    int   n;
    logic got;
    got = 1'b0;
    @(negedge i_clk);
    pix_valid = 1'b1;
    pix_col   = c;
    pix_data  = d;
    @(negedge i_clk);
    pix_valid = 1'b0;
    pix_col   = ~c;
    pix_data  = ~d;
    for (n = 0; n < 4 && got !== 1'b1; n++) begin
      @(negedge i_clk);
      got = opix_valid;
    end
    `FSCS_CHK(got, 1'b1)
    `FSCS_CHK(opix_data, e)
  endtask

  initial begin
    #(100000 * 40);
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (16) @(negedge i_clk);
    rst_b   = 1'b1;
    exp_act = {8'h01, 48'h0, 8'h00, 32'h0000_0001, 2'b00};
    `FSCS_CHK(act, exp_act)
    rd_chk(`FSCS_ADDR_SYNC, 16'h000F);
    rd_chk(`FSCS_ADDR_WIN_EN_LO, 16'h0001);
    // Each group frozen in turn while the others stay live
    for (g = 0; g < 4; g++) begin
      i_fscs_host.wr(`FSCS_ADDR_SYNC, 16'h000F & ~(16'h0001 << g));
      case (g)
        0: i_fscs_host.wr(`FSCS_ADDR_BLACK, 16'h0003);
        1: begin
          i_fscs_host.wr(`FSCS_ADDR_MULT, 16'h1111);
          i_fscs_host.wr(`FSCS_ADDR_FRLEN, 16'h2222);
          i_fscs_host.wr(`FSCS_ADDR_EXPO, 16'h3333);
        end
        2: i_fscs_host.wr(`FSCS_ADDR_GAIN, 16'h00B5);
        default: begin
          i_fscs_host.set_windows(32'h5A5A_A5A5, 32);
          i_fscs_host.wr(`FSCS_ADDR_MODE, 16'h0180);
        end
      endcase
      pulse(0);
      `FSCS_CHK(act, exp_act)
      rd_chk(ra[g], rv[g]);
      i_fscs_host.wr(`FSCS_ADDR_SYNC, 16'h000F);
      `FSCS_CHK(act, exp_act)
      pulse(0);
      exp_act = (exp_act & ~msk[g]) | (nv & msk[g]);
      `FSCS_CHK(act, exp_act)
    end
    i_fscs_host.wr(`FSCS_ADDR_SYNC, 16'hFFFF);
    rd_chk(`FSCS_ADDR_SYNC, 16'h000F);
    i_fscs_host.wr(9'h1FF, 16'h1234);
    rd_chk(9'h1FF, 16'h0000);
    rd_chk(`FSCS_ADDR_WIN_EN_HI, 16'h5A5A);
    // Geometry rewritten with the window gate closed, mid-acquisition
    i_fscs_host.wr(`FSCS_ADDR_SYNC, 16'h0007);
    i_fscs_host.wr(`FSCS_ADDR_WIN_EN_LO, 16'h0003);
    i_fscs_host.wr(`FSCS_ADDR_WIN_BASE, 16'hBEEF);
    i_fscs_host.wr(`FSCS_ADDR_WIN_LAST, 16'h1357);
    pulse(0);
    geom_addr = 7'h00;
    @(negedge i_clk);
    `FSCS_CHK(geom_data, 16'hBEEF)
    geom_addr = 7'h5F;
    @(negedge i_clk);
    `FSCS_CHK(geom_data, 16'h1357)
    `FSCS_CHK(act, exp_act)
    i_fscs_host.wr(`FSCS_ADDR_SYNC, 16'h000F);
    // Dark rows and per-column offsets toward a target of 0x40
    i_fscs_host.wr(`FSCS_ADDR_TARGET, 16'h0040);
    pulse(0);
    // Pending low enable word goes active once the window gate is back
    exp_act[17:2] = 16'h0003;
    `FSCS_CHK(act, exp_act)
    `FSCS_CHK(dark_row, 1'b1)
    pix(6'h05, 10'h010, 10'h010);
    pix(6'h06, 10'h050, 10'h050);
    for (r = 0; r < 3; r++) begin
      pulse(1);
      @(negedge i_clk);
      `FSCS_CHK(dark_row, (r < 2) ? 1'b1 : 1'b0)
    end
    pix(6'h05, 10'h100, 10'h130);
    pix(6'h06, 10'h005, 10'h000);
    pix(6'h05, 10'h3F0, 10'h3FF);
    stop_test();
  end
endmodule
